// >>> rtl/tpd_inband_det.sv
`timescale 1ns/1ps
`include "tpd_regs.svh"
// one inband code matcher with persistence timer
module tpd_inband_det #(
    parameter int unsigned HOLD_W = 27
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // data bit and its strobe
    input  wire logic              bit_valid,
    input  wire logic              bit_in,
    // target code; length field n selects an n+5 bit code, sent msb first
    input  wire logic [1:0]        code_length,
    input  wire logic [7:0]        code_word,
    input  wire logic [HOLD_W-1:0] hold_cycles,
    // result
    output logic                   detected
);
    logic [2:0]        phase_reg;       // position within repeated code
    logic [6:0]        blk_cnt_reg;     // bits in current 100-bit block
    logic [6:0]        blk_err_reg;     // errors in current block
    logic              present_reg;     // code seen within budget
    logic [HOLD_W-1:0] dwell_reg;       // how long code has persisted
    logic [3:0]        len;             // length in bits
    logic              expect_bit;
    logic              miss;

    // four length codes cover 5 to 8 bits; 3 and 4 bit codes are not supported
    assign len        = 4'(code_length) + 4'h5;
    // compare against code bit, msb first, repeating
    assign expect_bit = code_word[3'(len - 4'h1) - phase_reg];
    assign miss       = bit_in ^ expect_bit;

    // phase walks the code; while hunting, a miss holds the phase so the data slips one bit
    // against the code; restarting at the code start instead can cycle forever on some codes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 3'h0;
        end else if (bit_valid) begin
            if (miss && !present_reg) begin
                phase_reg <= phase_reg;
            end else if (phase_reg == 3'(len - 4'h1)) begin
                phase_reg <= 3'h0;
            end else begin
                phase_reg <= phase_reg + 3'h1;
            end
        end
    end

    // error rate no worse than one per hundred bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blk_cnt_reg <= 7'h00;
            blk_err_reg <= 7'h00;
            present_reg <= 1'b0;
        end else if (bit_valid) begin
            if (blk_cnt_reg == 7'(`TPD_IB_BLOCK_BITS - 1)) begin
                present_reg <= (blk_err_reg + 7'(miss)) <= 7'(`TPD_IB_BLOCK_ERRS);
                blk_cnt_reg <= 7'h00;
                blk_err_reg <= 7'h00;
            end else begin
                blk_cnt_reg <= blk_cnt_reg + 7'h01;
                blk_err_reg <= blk_err_reg + 7'(miss);
            end
        end
    end

    // persistence counter: saturates once the hold time is passed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dwell_reg <= '0;
            detected  <= 1'b0;
        end else if (!present_reg) begin
            dwell_reg <= '0;
            detected  <= 1'b0;
        end else if (dwell_reg > hold_cycles) begin
            detected  <= 1'b1;
        end else begin
            dwell_reg <= dwell_reg + HOLD_W'(1);
        end
    end
endmodule : tpd_inband_det

// >>> rtl/tpd_pkg.sv
package tpd_pkg;
    // raw error event strobes from the decoders
    typedef struct packed {
        logic line_bipolar_violation;
        logic line_excess_zeros;
        logic system_bipolar_violation;
        logic system_excess_zeros;
    } tpd_err_events_t;
    // sticky interrupt status flags
    typedef struct packed {
        logic pattern_lock;
        logic pattern_error;
        logic loopup;
        logic loopdown;
        logic second_tick;
        logic count_overflow;
    } tpd_irq_t;
    // pattern synchroniser states
    typedef enum logic [0:0] {
        TPD_HUNT,
        TPD_LOCKED
    } tpd_sync_state_t;
endpackage : tpd_pkg

// >>> rtl/tpd_prbs_det.sv
`timescale 1ns/1ps
`include "tpd_regs.svh"
// pattern reference and lock tracking
module tpd_prbs_det (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // data
    input  wire logic        bit_valid,
    input  wire logic        bit_in,
    // config
    input  wire logic [1:0]  pattern_select,
    input  wire logic [23:0] user_pattern_word,
    // results
    output logic             locked,
    output logic             bit_error
);
    logic [23:0] shift_reg;        // recent data, also seeds the lfsr
    logic [4:0]  user_ptr_reg;     // position in user word
    logic [5:0]  win_cnt_reg;      // bits in current window
    logic [5:0]  match_run_reg;    // consecutive matching bits in hunt
    logic [3:0]  win_err_reg;      // errors in current window
    logic        expect_bit;
    logic        miss;

    // reference regenerated from received bits user word fixed
    always_comb begin
        case (pattern_select)
            `TPD_SEL_QRSS20: expect_bit = shift_reg[2] ^ shift_reg[19];
            `TPD_SEL_PRBS15: expect_bit = shift_reg[13] ^ shift_reg[14];
            `TPD_SEL_PRBS11: expect_bit = shift_reg[8] ^ shift_reg[10];
            default:         expect_bit = user_pattern_word[user_ptr_reg];
        endcase
    end
    assign miss      = bit_in ^ expect_bit;
    assign bit_error = bit_valid && locked && miss;

    // self-synchronising shift register and user pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg    <= 24'h000000;
            user_ptr_reg <= 5'h17;
        end else if (bit_valid) begin
            shift_reg <= {shift_reg[22:0], bit_in};
            if (!locked && miss) begin
                user_ptr_reg <= 5'h17;
            end else if (user_ptr_reg == 5'h00) begin
                user_ptr_reg <= 5'h17;
            end else begin
                user_ptr_reg <= user_ptr_reg - 5'h01;
            end
        end
    end

    // lock after 64 clean bits in a row, drop on more than 6 errors per window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            locked        <= 1'b0;
            match_run_reg <= 6'h00;
            win_cnt_reg   <= 6'h00;
            win_err_reg   <= 4'h0;
        end else if (bit_valid) begin
            if (!locked) begin
                if (miss) begin
                    match_run_reg <= 6'h00;
                end else if (match_run_reg == 6'(`TPD_WINDOW_BITS - 1)) begin
                    locked      <= 1'b1;
                    win_cnt_reg <= 6'h00;
                    win_err_reg <= 4'h0;
                end else begin
                    match_run_reg <= match_run_reg + 6'h01;
                end
            end else begin
                win_cnt_reg <= win_cnt_reg + 6'h01;
                if (win_err_reg + 4'(miss) > 4'(`TPD_LOSS_ERRORS)) begin
                    locked        <= 1'b0;
                    match_run_reg <= 6'h00;
                end else if (win_cnt_reg == 6'(`TPD_WINDOW_BITS - 1)) begin
                    win_err_reg <= 4'h0;
                end else begin
                    win_err_reg <= win_err_reg + 4'(miss);
                end
            end
        end
    end
endmodule : tpd_prbs_det

// >>> rtl/tpd_regs.svh
`ifndef TPD_REGS_SVH
`define TPD_REGS_SVH
// detector pattern select codes
`define TPD_SEL_QRSS20      2'h0
`define TPD_SEL_PRBS15      2'h1
`define TPD_SEL_PRBS11      2'h2
`define TPD_SEL_USER        2'h3
// count source select codes
`define TPD_SRC_LINE_BIPOLAR_VIOLATION        3'h0
`define TPD_SRC_LINE_EXCESS_ZEROS        3'h1
`define TPD_SRC_LBOTH       3'h2
`define TPD_SRC_SYSTEM_BIPOLAR_VIOLATION        3'h3
`define TPD_SRC_SYSTEM_EXCESS_ZEROS        3'h4
`define TPD_SRC_SBOTH       3'h5
`define TPD_SRC_PATTERN     3'h6
// synchronisation window
`define TPD_WINDOW_BITS     64
`define TPD_LOSS_ERRORS     6
// inband error budget: one error per hundred bits
`define TPD_IB_BLOCK_BITS   100
`define TPD_IB_BLOCK_ERRS   1
// inband persistence times in microseconds
`define TPD_LOOPUP_US       40000
`define TPD_LOOPDOWN_US     30000
`define TPD_AUTO_US         5100000
// master clock rate and one second
`define TPD_CLK_HZ          20000000
`define TPD_SECOND_CYCLES   (`TPD_CLK_HZ)
`define TPD_US_TO_CYC(us)   ((us) * (`TPD_CLK_HZ / 1000000))
`endif

// >>> rtl/tpd_top.sv
`timescale 1ns/1ps
`include "tpd_regs.svh"
// Behaviour
// - optional inversion before pattern comparison
// - regenerate prbs or qrss from incoming data
// - user mode compares against 24-bit word
// - direction bit picks receive or transmit data
// - lock after 64 clean bits in a row
// - unlock on over six errors per window
// - count mismatches when locked, flag error interrupt
// - lock interrupt on rise or either edge
// - inband codes five to eight bits, programmable
// - inband present at error rate of at most 1/100
// - manual: loop-up 40ms, loop-down 30ms
// - auto: loop-up 5.1s, enter loopback
// - auto: loop-down 5.1s, leave loopback
// - inband interrupts on rise or either edge
// - one 16-bit counter, seven selectable sources
// - no system bpv count in nrz mode
// - mode one updates count every second
// - second timer from clock sets tick flag
// - update copies count, reloads live counter with this cycle's event
// - overflow flag when saturated and more errors
// - inband detection always runs
// - direction zero receive, one transmit
// - mode zero updates only on request
// - rising latch request triggers manual update
module tpd_top #(
    parameter int unsigned SECOND_CYCLES = `TPD_SECOND_CYCLES,
    parameter int unsigned LOOPUP_CYCLES = `TPD_US_TO_CYC(`TPD_LOOPUP_US),
    parameter int unsigned LOOPDN_CYCLES = `TPD_US_TO_CYC(`TPD_LOOPDOWN_US),
    parameter int unsigned AUTO_CYCLES   = `TPD_US_TO_CYC(`TPD_AUTO_US)
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // decoded data from the two paths
    input  wire logic                     rx_bit_valid,
    input  wire logic                     rx_bit,
    input  wire logic                     tx_bit_valid,
    input  wire logic                     tx_bit,
    // error strobes and tx format
    input  wire tpd_pkg::tpd_err_events_t err_events,
    input  wire logic                     tx_single_rail_nrz,
    // pattern detector config
    input  wire logic                     detect_invert,
    input  wire logic                     detect_direction,
    input  wire logic [1:0]               pattern_select,
    input  wire logic [23:0]              user_pattern_word,
    // inband config
    input  wire logic [1:0]               loopup_code_length,
    input  wire logic [1:0]               loopdown_code_length,
    input  wire logic [7:0]               loopup_code,
    input  wire logic [7:0]               loopdown_code,
    input  wire logic                     auto_loopback_enable,
    // edge selects and masks
    input  wire logic                     pattern_lock_edge_select,
    input  wire logic                     inband_edge_select,
    input  wire tpd_pkg::tpd_irq_t        irq_mask,
    input  wire tpd_pkg::tpd_irq_t        irq_clear,
    // counter config
    input  wire logic [2:0]               count_source_select,
    input  wire logic                     count_update_mode,
    input  wire logic                     count_latch_request,
    // status
    output logic                          pattern_lock_status,
    output logic                          loopup_status,
    output logic                          loopdown_status,
    output tpd_pkg::tpd_irq_t             irq_status,
    output logic                          irq_n,
    output logic [7:0]                    count_hold_high,
    output logic [7:0]                    count_hold_low,
    output logic                          remote_loopback,
    output logic                          digital_loopback
);
    localparam int unsigned HW = 27;     // wide enough for 5.1 s of cycles

    logic        sel_valid;              // strobe of chosen path
    logic        sel_bit;                // chosen and maybe inverted bit
    logic        lock;                   // synchroniser lock
    logic        pat_err;                // one pattern error strobe
    logic        up_det;                 // loop-up persisted
    logic        dn_det;                 // loop-down persisted
    logic        lock_d_reg;             // previous lock
    logic        up_d_reg;               // previous loop-up status
    logic        dn_d_reg;               // previous loop-down status
    logic        req_d_reg;              // previous latch request
    logic [31:0] sec_cnt_reg;            // one second divider
    logic        tick;                   // second expiry
    logic        update;                 // copy and restart event
    logic        count_event;            // selected error source fires
    logic [15:0] live_reg;               // live error counter
    logic [15:0] hold_reg;               // holding copy for the host
    logic [HW-1:0] up_hold;              // loop-up persistence
    logic [HW-1:0] dn_hold;              // loop-down persistence
    tpd_pkg::tpd_irq_t irq_set;          // this cycle's events

    // pick the path, then invert if asked
    assign sel_valid = detect_direction ? tx_bit_valid : rx_bit_valid;
    assign sel_bit   = (detect_direction ? tx_bit : rx_bit) ^ detect_invert;

    // pattern synchroniser and comparator
    tpd_prbs_det u_prbs (
        .clk               (clk),
        .rst               (rst),
        .bit_valid         (sel_valid),
        .bit_in            (sel_bit),
        .pattern_select    (pattern_select),
        .user_pattern_word (user_pattern_word),
        .locked            (lock),
        .bit_error         (pat_err)
    );
    assign pattern_lock_status = lock;

    // persistence limits depend on auto loopback
    assign up_hold = auto_loopback_enable ? HW'(AUTO_CYCLES) : HW'(LOOPUP_CYCLES);
    assign dn_hold = auto_loopback_enable ? HW'(AUTO_CYCLES) : HW'(LOOPDN_CYCLES);

    // inband matchers run regardless of pattern select
    tpd_inband_det #(.HOLD_W(HW)) u_up (
        .clk         (clk),
        .rst         (rst),
        .bit_valid   (sel_valid),
        .bit_in      (sel_bit),
        .code_length (loopup_code_length),
        .code_word   (loopup_code),
        .hold_cycles (up_hold),
        .detected    (up_det)
    );
    tpd_inband_det #(.HOLD_W(HW)) u_dn (
        .clk         (clk),
        .rst         (rst),
        .bit_valid   (sel_valid),
        .bit_in      (sel_bit),
        .code_length (loopdown_code_length),
        .code_word   (loopdown_code),
        .hold_cycles (dn_hold),
        .detected    (dn_det)
    );
    assign loopup_status   = up_det;
    assign loopdown_status = dn_det;

    // automatic loopback; clearing the enable also leaves it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remote_loopback  <= 1'b0;
            digital_loopback <= 1'b0;
        end else if (!auto_loopback_enable) begin
            remote_loopback  <= 1'b0;
            digital_loopback <= 1'b0;
        end else if (dn_det && !dn_d_reg) begin
            remote_loopback  <= 1'b0;
            digital_loopback <= 1'b0;
        end else if (up_det && !up_d_reg) begin
            remote_loopback  <= !detect_direction;
            digital_loopback <= detect_direction;
        end
    end

    // edge history for interrupt triggers and latch request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_d_reg <= 1'b0;
            up_d_reg   <= 1'b0;
            dn_d_reg   <= 1'b0;
            req_d_reg  <= 1'b0;
        end else begin
            lock_d_reg <= lock;
            up_d_reg   <= up_det;
            dn_d_reg   <= dn_det;
            req_d_reg  <= count_latch_request;
        end
    end

    // one second divider from the master clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_cnt_reg <= 32'h00000000;
        end else if (sec_cnt_reg == 32'(SECOND_CYCLES - 1)) begin
            sec_cnt_reg <= 32'h00000000;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
        end
    end
    assign tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));

    // update source by mode
    assign update = count_update_mode ? tick : (count_latch_request && !req_d_reg);

    // source selection; system bpv silent in single rail nrz
    always_comb begin
        case (count_source_select)
            `TPD_SRC_LINE_BIPOLAR_VIOLATION:    count_event = err_events.line_bipolar_violation;
            `TPD_SRC_LINE_EXCESS_ZEROS:    count_event = err_events.line_excess_zeros;
            `TPD_SRC_LBOTH:   count_event = err_events.line_bipolar_violation
                                          | err_events.line_excess_zeros;
            `TPD_SRC_SYSTEM_BIPOLAR_VIOLATION:    count_event = err_events.system_bipolar_violation && !tx_single_rail_nrz;
            `TPD_SRC_SYSTEM_EXCESS_ZEROS:    count_event = err_events.system_excess_zeros;
            `TPD_SRC_SBOTH:   count_event = !tx_single_rail_nrz && (err_events.system_bipolar_violation
                                          | err_events.system_excess_zeros);
            `TPD_SRC_PATTERN: count_event = pat_err;
            default:          count_event = 1'b0;
        endcase
    end

    // live counter restarts on update, saturates at all ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            live_reg <= 16'h0000;
        end else if (update) begin
            live_reg <= {15'h0000, count_event};
        end else if (count_event && live_reg != 16'hFFFF) begin
            live_reg <= live_reg + 16'h0001;
        end
    end

    // holding copy is all the host sees
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_reg <= 16'h0000;
        end else if (update) begin
            hold_reg <= live_reg;
        end
    end
    assign count_hold_high = hold_reg[15:8];
    assign count_hold_low  = hold_reg[7:0];

    // events feeding sticky status
    always_comb begin
        irq_set.pattern_lock   = (lock && !lock_d_reg) || (pattern_lock_edge_select && !lock && lock_d_reg);
        irq_set.pattern_error  = pat_err;
        irq_set.loopup         = (up_det && !up_d_reg) || (inband_edge_select && !up_det && up_d_reg);
        irq_set.loopdown       = (dn_det && !dn_d_reg) || (inband_edge_select && !dn_det && dn_d_reg);
        irq_set.second_tick    = tick;
        irq_set.count_overflow = count_event && live_reg == 16'hFFFF && !update;
    end

    // sticky flags: a set in the clear cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    // active-low interrupt from unmasked flags
    assign irq_n = ~|(irq_status & ~irq_mask);
endmodule : tpd_top

// >>> testbench/tpd_bit_source.sv
`timescale 1ns/1ps
// far-side data path: repeats a word msb first, one bit every second clock
module tpd_bit_source (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // pattern to send and its length in bits
    input  wire logic [23:0] word,
    input  wire logic [4:0]  period,
    // decoded bit towards the detector
    output logic             bit_valid,
    output logic             bit_out
);
    logic [4:0] idx_reg; // position of the next bit
    // gaps between strobes mimic a recovered clock slower than the master clock
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            bit_valid <= 1'b0;
            bit_out   <= 1'b0;
            idx_reg   <= 5'h00;
        end else if (bit_valid) begin
            bit_valid <= 1'b0;
            bit_out   <= ~bit_out; // released line must not show the last bit
        end else begin
            bit_valid <= 1'b1;
            bit_out   <= word[idx_reg];
            idx_reg   <= (idx_reg == 5'h00) ? period - 5'h01 : idx_reg - 5'h01;
        end
    end
endmodule : tpd_bit_source

// >>> testbench/tpd_top_asserts.sv
`timescale 1ns/1ps
// watcher on the top ports
module tpd_chk (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // controls
    input wire logic              count_update_mode,
    input wire logic              count_latch_request,
    input wire logic              auto_loopback_enable,
    input wire tpd_pkg::tpd_irq_t irq_mask,
    // status
    input wire logic              pattern_lock_status,
    input wire logic              loopup_status,
    input wire tpd_pkg::tpd_irq_t irq_status,
    input wire logic              irq_n,
    input wire logic [7:0]        count_hold_high,
    input wire logic [7:0]        count_hold_low,
    input wire logic              remote_loopback
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_irq_pin_merge: assert property (
        irq_n == ~|(irq_status & ~irq_mask)) else $error("irq pin disagrees with flags");
    chk_hold_quiet: assert property (
        (!count_update_mode && !count_latch_request) [*3] |-> $stable({count_hold_high, count_hold_low}))
        else $error("hold changed without request");
    chk_lock_flag: assert property (
        $rose(pattern_lock_status) |-> ##[0:1] irq_status.pattern_lock) else $error("lock flag missing");
    chk_loopup_flag: assert property (
        $rose(loopup_status) |-> ##[0:1] irq_status.loopup) else $error("loop-up flag missing");
    chk_auto_cause: assert property (
        $rose(remote_loopback) |-> ##[0:1] (loopup_status && auto_loopback_enable))
        else $error("loopback without cause");
    chk_manual_noloop: assert property (
        !auto_loopback_enable && !$past(auto_loopback_enable) |-> !$rose(remote_loopback))
        else $error("loopback in manual mode");
    chk_err_needs_lock: assert property (
        $rose(irq_status.pattern_error) |-> $past(pattern_lock_status)) else $error("error while unlocked");
    chk_tick_update: assert property (
        count_update_mode && $past(count_update_mode) && $changed({count_hold_high, count_hold_low})
        |-> ##[0:1] irq_status.second_tick) else $error("hold moved off tick");
endmodule : tpd_chk
bind tpd_top tpd_chk i_chk (.clk, .rst, .count_update_mode, .count_latch_request, .auto_loopback_enable,
    .irq_mask, .pattern_lock_status, .loopup_status, .irq_status, .irq_n, .count_hold_high, .count_hold_low,
    .remote_loopback);

// >>> testbench/tpd_top_tb.sv
`timescale 1ns/1ps
// self-checking bench: counter model with integers, pattern lock table
module tpd_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pv, pb, sel, nrz, inv, dir, auto_en, mode, latch, lock, lu, ld, irq_n, rlb, dlb;
    logic [1:0] psel, es, upl, dnl;
    logic [2:0] src;
    logic [4:0] period;
    logic [7:0] hh, hl, upc, dnc;
    logic [23:0] word;
    logic [3:0] tab [6] = '{4'h1, 4'h4, 4'h7, 4'hD, 4'h8, 4'hB}; // {dir, path, invert, lock}
    tpd_pkg::tpd_err_events_t ev;
    tpd_pkg::tpd_irq_t mask, clr, irqs;
    int failures = 0;
    int tests_run = 0;
    int seed = 32'h6AF1;
    int cnt;
    always #25 clk = ~clk;
    // the wrong path always carries the inverted stream
    tpd_top #(.SECOND_CYCLES(100), .LOOPUP_CYCLES(50), .LOOPDN_CYCLES(50), .AUTO_CYCLES(50)) i_dut (
        .clk, .rst, .rx_bit_valid(pv), .rx_bit(pb ^ sel), .tx_bit_valid(pv), .tx_bit(pb ^ ~sel),
        .err_events(ev), .tx_single_rail_nrz(nrz), .detect_invert(inv), .detect_direction(dir),
        .pattern_select(psel), .user_pattern_word(word), .loopup_code_length(upl),
        .loopdown_code_length(dnl), .loopup_code(upc), .loopdown_code(dnc),
        .auto_loopback_enable(auto_en), .pattern_lock_edge_select(es[0]), .inband_edge_select(es[1]),
        .irq_mask(mask), .irq_clear(clr), .count_source_select(src), .count_update_mode(mode),
        .count_latch_request(latch), .pattern_lock_status(lock), .loopup_status(lu), .loopdown_status(ld),
        .irq_status(irqs), .irq_n, .count_hold_high(hh), .count_hold_low(hl), .remote_loopback(rlb),
        .digital_loopback(dlb));
    tpd_bit_source i_src (.clk, .rst, .word, .period, .bit_valid(pv), .bit_out(pb));
    task automatic cmp_count(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_count
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_count({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_flag
    // rising request, hold valid one edge later, then a low edge before any next request
    task automatic latch_count();
        latch = 1'b1;
        repeat (2) @(negedge clk);
        latch = 1'b0;
        @(negedge clk);
    endtask : latch_count
    // random error pulses; bpv and exz never coincide so a combined source counts their sum
    task automatic burst(input int n);
        repeat (n) begin
            ev = 4'($random(seed));
            ev[2] = ev[2] & ~ev[3];
            ev[0] = ev[0] & ~ev[1];
            case (src)
                3'h0: cnt += ev[3];
                3'h1: cnt += ev[2];
                3'h2: cnt += ev[3] + ev[2];
                3'h3: cnt += nrz ? 0 : ev[1];
                3'h4: cnt += ev[0];
                3'h5: cnt += nrz ? 0 : ev[1] + ev[0];
                default: ;
            endcase
            @(negedge clk);
        end
        ev = '0;
    endtask : burst
    task automatic wait_tick();
        clr = '1;
        @(negedge clk);
        clr = '0;
        for (int k = 0; k < 120 && irqs.second_tick !== 1'b1; k++) @(negedge clk);
        cmp_flag(irqs.second_tick, 1'b1);
        cmp_flag(irq_n, mask.second_tick);
    endtask : wait_tick
    task automatic final_report();
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        #5000000;
        failures++;
        final_report();
    end
    initial begin
        {ev, nrz, inv, dir, sel, auto_en, mode, latch, src, mask, clr} = '0;
        psel = 2'h3;
        word = 24'h0F3A51;
        period = 5'h18;
        es = 2'($random(seed));
        {upl, dnl, upc, dnc} = {2'h3, 2'h1, 8'hB7, 8'h4C};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        foreach (tab[i]) begin
            {dir, sel, inv} = tab[i][3:1];
            repeat (700) @(negedge clk);
            cmp_flag(lock, tab[i][0]);
        end
        for (int i = 0; i < 14; i++) begin
            src = 3'(i % 7);
            nrz = (i >= 7);
            latch_count();
            cnt = 0;
            burst(40);
            repeat (150) @(negedge clk);
            latch_count();
            cmp_count({hh, hl}, 16'(cnt));
        end
        src = 3'h0;
        ev = 4'h8;
        repeat (65537) @(negedge clk);
        ev = '0;
        latch_count();
        cmp_count({hh, hl}, 16'hFFFF);
        cmp_flag(irqs.count_overflow, 1'b1);
        mode = 1'b1;
        wait_tick();
        cnt = 0;
        burst(50);
        mask.second_tick = 1'b1;
        wait_tick();
        cmp_count({hh, hl}, 16'(cnt));
        {dir, sel, inv, auto_en} = 4'h1;
        period = 5'h08;
        word = 24'h0000B7;
        for (int k = 0; k < 3000 && rlb !== 1'b1; k++) @(negedge clk);
        cmp_flag(rlb, 1'b1);
        cmp_flag(lu, 1'b1);
        cmp_flag(dlb, 1'b0);
        period = 5'h06;
        word = 24'h00004C;
        for (int k = 0; k < 3000 && rlb !== 1'b0; k++) @(negedge clk);
        cmp_flag(rlb, 1'b0);
        cmp_flag(ld, 1'b1);
        final_report();
    end
endmodule : tpd_top_tb
